// file: sim/config_write_protection_test.sv
// testbench for the configuration write guard
`timescale 1ns/1ps
module config_write_protection_test
	import cwp_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic sclk, mosi, cs_n, miso, miso_oe_n, lock_armed, cfg_xfer_pulse;
	logic [2:0] chip_addr_pin = 3'h3;
	logic [2:0] chip_sel = 3'h3;
	logic [15:0] int_event = 16'h0000;
	logic [15:0] status_in = 16'h5a5a;
	logic [15:0] adc_in = 16'h0c3a;
	logic [15:0] adcdec_in = 16'h03c5;
	logic [CWP_NREG*CWP_WORD-1:0] cfg_snapshot;
	logic [15:0] int_flags;
	logic [15:0] shadow [CWP_NREG];
	int failures = 0;
	int cmp_count = 0;
	int xfer_count = 0;

	always #4 ref_clk = ~ref_clk;
	always @(negedge ref_clk) if (cfg_xfer_pulse === 1'b1) xfer_count++;

	cwp_guard_top #(.REVISION(4'ha)) cwp_guard_top_inst (.ref_clk(ref_clk), .rstn(rstn),
		.sclk(sclk), .mosi(mosi), .cs_n(cs_n), .chip_addr_pin(chip_addr_pin),
		.int_event(int_event), .status_in(status_in), .adc_in(adc_in),
		.adcdec_in(adcdec_in), .miso(miso), .miso_oe_n(miso_oe_n), .lock_armed(lock_armed),
		.cfg_xfer_pulse(cfg_xfer_pulse), .cfg_snapshot(cfg_snapshot), .int_flags(int_flags));

	cwp_host_model cwp_host_model_inst (.ref_clk(ref_clk), .sclk(sclk), .mosi(mosi),
		.cs_n(cs_n), .miso(miso), .miso_oe_n(miso_oe_n));

	function automatic logic [15:0] ctrl_exp(input logic [15:0] v);
		return (v & 16'hfe1b) | 16'h0140;
	endfunction : ctrl_exp

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic wr(input logic [10:0] a, input logic [15:0] d);
		logic [15:0] r;
		cwp_host_model_inst.frame('{bcast:1'b0, addr:a, rd:1'b0, chip:chip_sel}, d, r);
	endtask : wr

	task automatic rd(input logic [10:0] a, input logic [15:0] exp);
		logic [15:0] r;
		cwp_host_model_inst.frame('{bcast:1'b0, addr:a, rd:1'b1, chip:chip_sel}, 16'h0000, r);
		check(r, exp);
	endtask : rd

	task automatic done(input string name);
		$display("test %s finished", name);
	endtask : done

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish

	initial begin
		repeat (60000) @(posedge ref_clk);
		failures++;
		tally_and_finish();
	end

	initial begin
		for (int a = 0; a < CWP_NREG; a++) shadow[a] = CWP_RST[a];
		repeat (6) @(negedge ref_clk);
		rstn = 1'b1;
		repeat (6) @(negedge ref_clk);
		check({15'h0, lock_armed}, 16'h0000);
		rd(CWP_ADDR_LOCK, 16'h0000);
		rd(CWP_ADDR_CTRL, ctrl_exp(16'h1080));
		done("reset");
		for (int a = 2; a < CWP_NREG; a++) begin
			if (a < 12 || a > 15) begin
				shadow[a] = 16'h5a00 ^ (16'(a) * 16'h0101);
				wr(11'(a), shadow[a]);
				rd(11'(a), shadow[a]);
			end
		end
		wr(CWP_ADDR_CTRL, 16'h0001);
		rd(CWP_ADDR_CTRL, ctrl_exp(16'h0001));
		done("unlocked");
		wr(CWP_ADDR_LOCK, CWP_KEY_ARM);
		rd(CWP_ADDR_LOCK, 16'h0001);
		check({15'h0, lock_armed}, 16'h0001);
		check(16'(xfer_count), 16'h0001);
		for (int a = 2; a < CWP_NREG; a++) begin
			if (a < 12 || a > 15) begin
				check(cfg_snapshot[a*16+:16], shadow[a]);
				wr(11'(a), ~shadow[a]);
				rd(11'(a), shadow[a]);
			end
		end
		done("armed");
		@(negedge ref_clk) int_event = 16'h00ff;
		@(negedge ref_clk) int_event = 16'h0000;
		rd(CWP_ADDR_INT, 16'h00ff);
		check(int_flags, 16'h00ff);
		wr(CWP_ADDR_INT, 16'h000f);
		rd(CWP_ADDR_INT, 16'h00f0);
		chip_addr_pin = 3'h6;
		wr(CWP_ADDR_CTRL, 16'h0004);
		chip_sel = 3'h6;
		rd(CWP_ADDR_LOCK, 16'h0001);
		rd(CWP_ADDR_CTRL, ctrl_exp(16'h0001));
		rd(CWP_ADDR_STATUS, 16'h5a5a);
		rd(CWP_ADDR_ADC, 16'h0c3a);
		rd(CWP_ADDR_ADCDEC, 16'h03c5);
		rd(11'h7ff, 16'h0000);
		done("exempt");
		wr(CWP_ADDR_LOCK, 16'h1234);
		rd(CWP_ADDR_LOCK, 16'h0001);
		wr(CWP_ADDR_LOCK, CWP_KEY_DISARM);
		rd(CWP_ADDR_LOCK, 16'h0000);
		check({15'h0, lock_armed}, 16'h0000);
		wr(CWP_ADDR_LOCK, 16'hade2);
		rd(CWP_ADDR_LOCK, 16'h0000);
		check(16'(xfer_count), 16'h0001);
		shadow[3] = 16'hbeef;
		wr(11'h003, shadow[3]);
		rd(11'h003, shadow[3]);
		wr(CWP_ADDR_LOCK, CWP_KEY_ARM);
		rd(CWP_ADDR_LOCK, 16'h0001);
		check(16'(xfer_count), 16'h0002);
		check(cfg_snapshot[3*16+:16], 16'hbeef);
		done("keys");
		// reset while armed must leave the guard open again
		@(negedge ref_clk) rstn = 1'b0;
		repeat (6) @(negedge ref_clk);
		rstn = 1'b1;
		repeat (6) @(negedge ref_clk);
		check({15'h0, lock_armed}, 16'h0000);
		rd(CWP_ADDR_LOCK, 16'h0000);
		rd(11'h003, CWP_RST[3]);
		wr(11'h003, 16'h1357);
		rd(11'h003, 16'h1357);
		done("second reset");
		tally_and_finish();
	end
endmodule : config_write_protection_test

// file: sim/cwp_host_model.sv
// host spi master model: one 32-bit frame per call
`timescale 1ns/1ps
module cwp_host_model
	import cwp_pkg::*;
#(
	parameter int HALF = 7
)
(
	input wire logic ref_clk,
	output logic sclk,
	output logic mosi,
	output logic cs_n,
	input wire logic miso,
	input wire logic miso_oe_n
);
	initial begin
		sclk = 1'b0;
		mosi = 1'b0;
		cs_n = 1'b1;
	end

	// half period of 7 cycles keeps sclk under 10 MHz
	task automatic frame(input cwp_hdr_s hdr, input logic [15:0] wd, output logic [15:0] rdv);
		logic [31:0] word;
		word = {hdr, wd};
		rdv = 16'h0000;
		@(negedge ref_clk);
		cs_n = 1'b0;
		for (int i = 31; i >= 0; i--) begin
			mosi = word[i];
			repeat (HALF) @(negedge ref_clk);
			sclk = 1'b1;
			if (i < 16)
				rdv[i] = (miso_oe_n === 1'b0) ? miso : 1'bx;
			repeat (HALF) @(negedge ref_clk);
			sclk = 1'b0;
		end
		// released line must not keep the last bit
		mosi = ~mosi;
		repeat (2) @(negedge ref_clk);
		cs_n = 1'b1;
		repeat (10) @(negedge ref_clk);
	endtask : frame
endmodule : cwp_host_model

// file: src/cwp_guard_top.sv
// register bank with configuration write guard behind the spi port
`timescale 1ns/1ps
module cwp_guard_top
	import cwp_pkg::*;
#(
	parameter logic [3:0] REVISION = 4'h1 // arbitrary value
)
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic sclk,
	input wire logic mosi,
	input wire logic cs_n,
	input wire logic [2:0] chip_addr_pin,
	input wire logic [15:0] int_event,
	input wire logic [15:0] status_in,
	input wire logic [15:0] adc_in,
	input wire logic [15:0] adcdec_in,
	output logic miso,
	output logic miso_oe_n,
	output logic lock_armed,
	output logic cfg_xfer_pulse,
	output logic [CWP_NREG*CWP_WORD-1:0] cfg_snapshot,
	output logic [CWP_WORD-1:0] int_flags
);
	logic [2:0] chip_s1, chip_s2;
	logic [2:0] chip_reg;
	logic chip_init_reg;
	logic [15:0] cfg_reg [CWP_NREG];
	logic lock_reg;
	logic [15:0] int_reg;
	logic [15:0] rd_word;
	cwp_hdr_s hdr;
	logic wr_valid;
	logic [15:0] wr_data;
	logic wr_lock, wr_int, wr_ctrl, wr_cfg;

	cwp_spi_slave u_spi (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.sclk(sclk),
		.mosi(mosi),
		.cs_n(cs_n),
		.my_chip(chip_reg),
		.rd_word(rd_word),
		.hdr(hdr),
		.wr_valid(wr_valid),
		.wr_data(wr_data),
		.miso(miso),
		.miso_oe_n(miso_oe_n)
	);

	assign wr_lock = wr_valid && hdr.addr == CWP_ADDR_LOCK;
	assign wr_int = wr_valid && hdr.addr == CWP_ADDR_INT;
	assign wr_ctrl = wr_valid && hdr.addr == CWP_ADDR_CTRL;
	assign wr_cfg = wr_valid && cwp_is_cfg(hdr.addr);

	// no reset, so the strap is already through both flops when reset lifts
	always_ff @(posedge ref_clk) begin
		chip_s1 <= chip_addr_pin;
		chip_s2 <= chip_s1;
	end

	// strap caught once after reset, then only on a reload request
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			chip_reg <= 3'h0;
			chip_init_reg <= 1'b0;
		end else begin
			chip_init_reg <= 1'b1;
			if (!chip_init_reg || (wr_ctrl && wr_data[CWP_RELOAD_BIT])) begin
				chip_reg <= chip_s2;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			lock_reg <= CWP_LOCK_RST;
		end else if (wr_lock) begin
			if (wr_data == CWP_KEY_ARM) begin
				lock_reg <= 1'b1;
			end else if (wr_data == CWP_KEY_DISARM) begin
				lock_reg <= 1'b0;
			end
		end
	end

	// blocked writes are dropped without any error indication
	always_ff @(posedge ref_clk) begin
		for (int i = 0; i < CWP_NREG; i++) begin
			if (!rstn) begin
				cfg_reg[i] <= CWP_RST[i];
			end else if (wr_cfg && !lock_reg && hdr.addr == 11'(i)) begin
				cfg_reg[i] <= wr_data;
			end
		end
	end

	// an event in the clearing cycle keeps its flag
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			int_reg <= CWP_INT_RST;
		end else begin
			int_reg <= (int_reg & ~(wr_int ? wr_data : 16'h0000)) | int_event;
		end
	end

	// arming copies the configuration across to the consumer side
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			cfg_xfer_pulse <= 1'b0;
			cfg_snapshot <= '0;
		end else begin
			cfg_xfer_pulse <= wr_lock && wr_data == CWP_KEY_ARM;
			if (wr_lock && wr_data == CWP_KEY_ARM) begin
				for (int i = 0; i < CWP_NREG; i++) begin
					cfg_snapshot[i*CWP_WORD +: CWP_WORD] <= cfg_reg[i];
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			lock_armed <= CWP_LOCK_RST;
			int_flags <= CWP_INT_RST;
		end else begin
			lock_armed <= lock_reg;
			int_flags <= int_reg;
		end
	end

	always_comb begin
		rd_word = 16'h0000;
		if (hdr.addr == CWP_ADDR_LOCK) begin
			rd_word[CWP_LOCK_BIT] = lock_reg;
		end else if (hdr.addr == CWP_ADDR_INT) begin
			rd_word = int_reg;
		end else if (hdr.addr == CWP_ADDR_STATUS) begin
			rd_word = status_in;
		end else if (hdr.addr == CWP_ADDR_ADC) begin
			rd_word = adc_in;
		end else if (hdr.addr == CWP_ADDR_ADCDEC) begin
			rd_word = adcdec_in;
		end else if (cwp_is_cfg(hdr.addr)) begin
			rd_word = cfg_reg[hdr.addr[CWP_IDX_W-1:0]];
			if (hdr.addr == CWP_ADDR_CTRL) begin
				rd_word[CWP_REV_MSB:CWP_REV_LSB] = REVISION;
				rd_word[CWP_RELOAD_BIT] = 1'b0;
			end
		end
	end

	reset_unlocked_a: assert property (@(posedge ref_clk)
		!rstn |=> !lock_reg) else $error("guard armed after reset");

	arm_key_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		wr_lock && wr_data == CWP_KEY_ARM |=> lock_reg && cfg_xfer_pulse ##1 !cfg_xfer_pulse)
		else $error("arm key did not arm and transfer once");

	locked_block_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		lock_reg && wr_cfg |=> $stable(cfg_reg[$past(hdr.addr[CWP_IDX_W-1:0])]))
		else $error("configuration changed while armed");

	unlocked_write_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		!lock_reg && wr_cfg |=> cfg_reg[$past(hdr.addr[CWP_IDX_W-1:0])] == $past(wr_data))
		else $error("write lost while disarmed");

	lock_readback_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		hdr.addr == CWP_ADDR_LOCK |-> rd_word == {15'h0000, lock_reg})
		else $error("guard key read does not show state");

	int_clear_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		lock_reg && wr_int && wr_data[0] && !int_event[0] |=> !int_reg[0])
		else $error("flag not cleared while armed");

	disarm_key_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		lock_reg && wr_lock && wr_data == CWP_KEY_DISARM |=> !lock_reg ##1 !lock_armed)
		else $error("disarm key did not disarm");

	revision_field_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		hdr.addr == CWP_ADDR_CTRL |-> rd_word[CWP_REV_MSB:CWP_REV_LSB] == REVISION)
		else $error("revision field wrong");

	flag_keep_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		int_reg[0] && !(wr_int && wr_data[0]) |=> int_reg[0])
		else $error("flag lost without a one written");

	other_key_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		wr_lock && wr_data != CWP_KEY_ARM && wr_data != CWP_KEY_DISARM |=> $stable(lock_reg))
		else $error("stray key changed guard state");

	reload_capture_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		wr_ctrl && wr_data[CWP_RELOAD_BIT] |=> chip_reg == $past(chip_s2))
		else $error("address reload not taken");

	xfer_only_arm_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		!(wr_lock && wr_data == CWP_KEY_ARM) |=> !cfg_xfer_pulse)
		else $error("transfer pulse without arm key");

	snapshot_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		!(wr_lock && wr_data == CWP_KEY_ARM) |=> $stable(cfg_snapshot))
		else $error("snapshot changed without arm key");

	armed_output_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		lock_armed == $past(lock_reg))
		else $error("armed output does not follow guard");

	flags_output_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		int_flags == $past(int_reg))
		else $error("flag output does not follow flags");

	flag_set_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		int_event[0] |=> int_reg[0])
		else $error("event did not set its flag");

	reset_outputs_a: assert property (@(posedge ref_clk)
		!rstn |=> !lock_armed && !cfg_xfer_pulse && int_flags == CWP_INT_RST)
		else $error("outputs not cleared by reset");

	stray_write_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		wr_valid && !wr_cfg && !wr_lock |=> $stable(lock_reg) && !cfg_xfer_pulse)
		else $error("stray write changed the guard");
endmodule : cwp_guard_top

// file: src/cwp_pkg.sv
// constants, types and register map of the configuration write guard
package cwp_pkg;
	localparam int CWP_WORD = 16;
	localparam int CWP_NREG = 19;
	localparam int CWP_IDX_W = 5;
	localparam logic [10:0] CWP_ADDR_LOCK = 11'h000;
	localparam logic [10:0] CWP_ADDR_CTRL = 11'h001;
	localparam logic [10:0] CWP_ADDR_MASK = 11'h00b;
	localparam logic [10:0] CWP_ADDR_INT = 11'h00c;
	localparam logic [10:0] CWP_ADDR_STATUS = 11'h00d;
	localparam logic [10:0] CWP_ADDR_ADC = 11'h00e;
	localparam logic [10:0] CWP_ADDR_ADCDEC = 11'h00f;
	localparam logic [10:0] CWP_ADDR_PL_LO = 11'h010;
	localparam logic [10:0] CWP_ADDR_PL_HI = 11'h012;
	localparam logic [15:0] CWP_KEY_ARM = 16'hade1;
	localparam logic [15:0] CWP_KEY_DISARM = 16'hade0;
	localparam int CWP_LOCK_BIT = 0;
	localparam int CWP_REV_LSB = 5;
	localparam int CWP_REV_MSB = 8;
	localparam int CWP_RELOAD_BIT = 2;
	localparam logic CWP_LOCK_RST = 1'b0;
	localparam logic [15:0] CWP_INT_RST = 16'h0000;
	localparam logic [5:0] CWP_HDR_LAST = 6'h0f;
	localparam logic [5:0] CWP_DATA_FIRST = 6'h10;
	localparam logic [5:0] CWP_FRAME_LAST = 6'h1f;
	// index 0 is the guard key slot, held apart; its entry is unused
	localparam logic [15:0] CWP_RST [CWP_NREG] = '{
		16'h0000, 16'h1080, 16'h3610, 16'h5aaa, 16'hcccc, 16'h5a88, 16'h2d2d,
		16'h0096, 16'h80fa, 16'h80fa, 16'h80fa, 16'h4000, 16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'h0000, 16'h001e, 16'h001e};

	typedef struct packed {
		logic bcast;
		logic [10:0] addr;
		logic rd;
		logic [2:0] chip;
	} cwp_hdr_s;

	// user-writable configuration register other than the guard key
	function automatic logic cwp_is_cfg(input logic [10:0] a);
		return (a >= CWP_ADDR_CTRL && a <= CWP_ADDR_MASK) ||
			(a >= CWP_ADDR_PL_LO && a <= CWP_ADDR_PL_HI);
	endfunction : cwp_is_cfg
endpackage : cwp_pkg

// file: src/cwp_spi_slave.sv
// spi slave for 32-bit frames: header decode, write data capture, read data shift-out
`timescale 1ns/1ps
module cwp_spi_slave
	import cwp_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic sclk,
	input wire logic mosi,
	input wire logic cs_n,
	input wire logic [2:0] my_chip,
	input wire logic [15:0] rd_word,
	output cwp_hdr_s hdr,
	output logic wr_valid,
	output logic [15:0] wr_data,
	output logic miso,
	output logic miso_oe_n
);
	logic sclk_s1, sclk_s2, sclk_s3;
	logic mosi_s1, mosi_s2;
	logic cs_s1, cs_s2;
	logic [5:0] cnt_reg;
	logic [15:0] shift_reg;
	logic [15:0] tx_reg;
	logic rd_act_reg;
	logic loaded_reg;
	logic rise, fall;
	logic [15:0] word_next;
	cwp_hdr_s hdr_next;

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			{sclk_s1, sclk_s2, sclk_s3} <= 3'h0;
			{mosi_s1, mosi_s2} <= 2'h0;
			{cs_s1, cs_s2} <= 2'h3;
		end else begin
			{sclk_s1, sclk_s2, sclk_s3} <= {sclk, sclk_s1, sclk_s2};
			{mosi_s1, mosi_s2} <= {mosi, mosi_s1};
			{cs_s1, cs_s2} <= {cs_n, cs_s1};
		end
	end

	// host drives on falling sclk, we sample on rising
	assign rise = sclk_s2 && !sclk_s3;
	assign fall = !sclk_s2 && sclk_s3;
	assign word_next = {shift_reg[14:0], mosi_s2};
	assign hdr_next = cwp_hdr_s'(word_next);

	// frame counter; a rising chip select aborts the frame
	always_ff @(posedge ref_clk) begin
		if (!rstn || cs_s2) begin
			cnt_reg <= 6'h00;
			shift_reg <= 16'h0000;
		end else if (rise) begin
			shift_reg <= word_next;
			// stops one past the last bit so extra clocks cannot repeat the write
			if (cnt_reg <= CWP_FRAME_LAST) begin
				cnt_reg <= cnt_reg + 6'h01;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			hdr <= '0;
			rd_act_reg <= 1'b0;
		end else if (cs_s2) begin
			rd_act_reg <= 1'b0;
		end else if (rise && cnt_reg == CWP_HDR_LAST) begin
			hdr <= hdr_next;
			rd_act_reg <= hdr_next.rd && !hdr_next.bcast && hdr_next.chip == my_chip;
		end
	end

	// broadcast writes ignore the chip address
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			wr_valid <= 1'b0;
			wr_data <= 16'h0000;
		end else begin
			wr_valid <= !cs_s2 && rise && cnt_reg == CWP_FRAME_LAST && !hdr.rd &&
				(hdr.bcast || hdr.chip == my_chip);
			if (rise && cnt_reg == CWP_FRAME_LAST) begin
				wr_data <= word_next;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn || cs_s2) begin
			miso <= 1'b0;
			miso_oe_n <= 1'b1;
			tx_reg <= 16'h0000;
			loaded_reg <= 1'b0;
		end else if (fall && rd_act_reg) begin
			if (!loaded_reg) begin
				miso <= rd_word[15];
				tx_reg <= {rd_word[14:0], 1'b0};
				loaded_reg <= 1'b1;
				miso_oe_n <= 1'b0;
			end else begin
				miso <= tx_reg[15];
				tx_reg <= {tx_reg[14:0], 1'b0};
			end
		end
	end

	miso_release_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		cs_s2 |=> miso_oe_n) else $error("miso driven outside a frame");
endmodule : cwp_spi_slave
